// ===== common/sqd_pkg.sv
// package: constants and carriers for the squib driver control block
package sqd_pkg;
   // =====================================================
   // message layout
   localparam int MSG_W        = 16;
   localparam int B_MODE_HI    = 15;
   localparam int B_MODE_LO    = 14;
   localparam int B_PARITY     = 13;
   localparam int B_WRITE      = 12;
   localparam int B_RSEL       = 11;
   localparam int B_COND       = 10;
   localparam int B_PER_HI     = 9;
   localparam int B_PER_LO     = 8;
   localparam int B_MOSEN      = 11;
   localparam int B_HSSEL      = 10;
   localparam int B_CUREN      = 9;
   localparam int B_SRCSEL     = 8;
   localparam int B_AOUTEN     = 7;
   localparam int B_MON_HI     = 6;
   localparam int B_MON_LO     = 4;
   localparam int B_CUR_HI     = 2;
   localparam int B_CUR_LO     = 0;
   localparam int N_CH         = 8;
   localparam logic [7:0] RST_PAT1 = 8'haa;
   localparam logic [7:0] RST_PAT2 = 8'h55;
   // =====================================================
   // response header codes (d15..d13)
   localparam logic [2:0] RSP_REG   = 3'h0;
   localparam logic [2:0] RSP_CMD   = 3'h2;
   localparam logic [2:0] RSP_DIAG  = 3'h4;
   localparam logic [2:0] RSP_DIAGF = 3'h5;
   localparam logic [2:0] RSP_STAT  = 3'h6;
   localparam logic [2:0] RSP_FAULT = 3'h7;
   // =====================================================
   // reset values
   localparam logic [1:0] PER_RST  = 2'h0;
   localparam logic       COND_RST = 1'b0;
   // =====================================================
   // timing
   localparam int CLK_MHZ          = 100;
   localparam int TIMEOUT_US       = 1000;
   localparam int FLT_DLY_US       = 10;
   localparam int TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
   localparam int FLT_DLY_CYC      = FLT_DLY_US * CLK_MHZ;

   typedef enum logic [1:0] {
      MODE_REG  = 2'b00,
      MODE_CMD  = 2'b01,
      MODE_DIAG = 2'b10,
      MODE_MON  = 2'b11
   } sqd_mode_e;

   typedef enum logic [1:0] {
      MOS_IDLE = 2'b00,
      MOS_LS   = 2'b01,
      MOS_HS   = 2'b10
   } sqd_mos_e;

   // comparator bundle for the monitored channel
   typedef struct packed {
      logic batt_short;   // high_side_output above battery_short_threshold
      logic gnd_short;    // low_side_output below ground_short_threshold
      logic over_current; // difference above driver_current_threshold
   } sqd_cmp_s;

   // driver steering outputs
   typedef struct packed {
      logic [7:0] hs_on;
      logic [7:0] ls_on;
   } sqd_drv_s;
endpackage : sqd_pkg

// ===== rtl/sqd_ctrl.sv
// squib driver control: spi message decode, diagnostics sequencing
`timescale 1ns/100ps
// =====================================================
// Notes on behaviour
// (R01) report battery short and ground short/open
// (R02) resistance measure: source, sink, analog out
// (R03) host prechecks shorts before mos diagnostic
// (R04) deploy enable low: diagnostic runs, driver off
// (R05) low side precheck fails: ignore, flag d13 d7
// (R06) low side ends on any terminating comparator
// (R07) termination conditions latched as status bits
// (R08) low side timeout and fault filter
// (R09) high side precheck fails: ignore, flag
// (R10) high side ends on any terminating comparator
// (R11) high side timeout, same filter
// (R12) lost ground blocks channel, ls diag faults
// (R13) response returned in next framed transfer
// (R14) sixteen bit messages, top two bits mode
// (R15) response header codes per mode, 111 fault
// (R16) odd parity over all sixteen bits
// (R17) register read returns timer register
// (R18) register write: d11 selects period or reset
// (R19) d10 selects deployment condition, default 0
// (R20) d9..d8 stretch period, default 00
// (R21) soft reset needs aa then 55 consecutive
// (R22) soft reset like por, not while deploying; the response word is kept across it
// (R23) deploy enable low blocks both drivers
// (R24) diag d11 enables mos, d10 picks side
// (R25) comparators synchronised before use
module sqd_ctrl #(
   parameter int TIMEOUT_CYCLES = sqd_pkg::TIMEOUT_CYC,
   parameter int FILTER_CYCLES  = sqd_pkg::FLT_DLY_CYC
) (
   // system
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   // spi link (own clock domain, mode 0)
   input  wire logic              sclk_in,
   input  wire logic              csn_in,
   input  wire logic              mosi_in,
   output logic                   miso_out,
   output logic                   miso_oen_out,
   // analog comparators for the monitored channel, asynchronous
   input  wire sqd_pkg::sqd_cmp_s cmp_in,
   input  wire logic              deploy_enable_input_in,
   input  wire logic [7:0]        ground_lost_in,
   input  wire logic              deploy_busy_in,
   // outputs to the analog section
   output sqd_pkg::sqd_drv_s      drv_out,
   output logic                   bias_current_source_out,
   output logic                   measure_current_source_out,
   output logic                   measure_current_sink_out,
   output logic                   aout_enable_out,
   output logic [2:0]             monitor_chan_out,
   output logic [2:0]             current_chan_out,
   output logic [1:0]             stretch_period_out,
   output logic                   deploy_cond_out,
   output logic [7:0]             deploy_cmd_out,
   output logic                   deploy_cmd_stb_out,
   output logic                   soft_reset_out
);
   // =====================================================
   // link domain: shift register and response shifter
   logic [15:0] rx_sh_r;
   logic [3:0]  rx_cnt_r;
   logic [15:0] rx_word_r;
   logic        rx_tog_r;
   logic [3:0]  tx_cnt_r;
   logic [15:0] rsp_r;
   wire         rx_last = !csn_in && rx_cnt_r == 4'hf;

   // sclk only runs inside a frame, so the select itself clears the bit count
   always_ff @(posedge sclk_in or posedge csn_in) begin
      if (csn_in) begin
         rx_cnt_r <= 4'h0;
      end else begin
         rx_cnt_r <= rx_cnt_r + 4'h1;
      end
   end

   // rx shifts on rising sclk, msb first
   always_ff @(posedge sclk_in) begin
      if (!csn_in) begin
         rx_sh_r <= {rx_sh_r[14:0], mosi_in};
      end
      if (rx_last) begin // R14
         rx_word_r <= {rx_sh_r[14:0], mosi_in};
      end
   end

   // word toggle needs a known start; sclk may not run before the first word
   always_ff @(posedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_tog_r <= 1'b0;
      end else if (rx_last) begin
         rx_tog_r <= ~rx_tog_r;
      end
   end

   // tx: bit pointer advances on falling sclk, first bit valid at select fall
   always_ff @(negedge sclk_in or posedge csn_in) begin
      if (csn_in) begin
         tx_cnt_r <= 4'h0;
      end else begin
         tx_cnt_r <= tx_cnt_r + 4'h1;
      end
   end
   // rsp_r only moves a few clocks after the select rises and frames are
   // spaced wider than that, so it is static while the link reads it
   assign miso_out     = rsp_r[4'hf - tx_cnt_r]; // R13
   assign miso_oen_out = csn_in;

   // =====================================================
   // crossings into clk_in
   logic [2:0] tog_sync_r;
   logic [2:0] cs_sync_r;
   logic [2:0] cmp_s1_r;
   logic [2:0] cmp_s2_r;
   logic       den_s1_r;
   logic       den_s2_r;
   logic       frame_seen_r;
   always_ff @(posedge clk_in) begin
      tog_sync_r <= {tog_sync_r[1:0], rx_tog_r};
      cs_sync_r  <= {cs_sync_r[1:0], csn_in};
      cmp_s1_r   <= cmp_in; // R25
      cmp_s2_r   <= cmp_s1_r;
      den_s1_r   <= deploy_enable_input_in;
      den_s2_r   <= den_s1_r;
   end
   wire word_stb = tog_sync_r[2] ^ tog_sync_r[1];
   // a frame that closes without a full word is dropped: no take, response left unchanged
   // edge taken from settled stages only, never from the first flop
   wire cs_rise  = cs_sync_r[2] == 1'b0 && cs_sync_r[1] == 1'b1;
   logic [15:0] msg_r;
   always_ff @(posedge clk_in) begin
      if (word_stb) begin
         msg_r <= rx_word_r;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rstn_in || cs_rise) begin
         frame_seen_r <= 1'b0;
      end else if (word_stb) begin
         frame_seen_r <= 1'b1;
      end
   end

   // =====================================================
   // filtered comparators
   function automatic logic [31:0] cnt_step(input logic [31:0] c, input logic hit,
                                           input int lim);
      if (!hit) begin
         cnt_step = 32'h0;
      end else if (c < 32'(lim)) begin
         cnt_step = c + 32'h1;
      end else begin
         cnt_step = c;
      end
   endfunction : cnt_step

   logic [31:0] flt_cnt_r [3];
   logic [2:0]  cmp_f;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_flt
         always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
               flt_cnt_r[gi] <= 32'h0;
            end else begin
               flt_cnt_r[gi] <= cnt_step(flt_cnt_r[gi], cmp_s2_r[gi], FILTER_CYCLES); // R08
            end
         end
         assign cmp_f[gi] = flt_cnt_r[gi] >= 32'(FILTER_CYCLES);
      end
   endgenerate
   sqd_pkg::sqd_cmp_s cmpf;
   assign cmpf = cmp_f;

   // =====================================================
   // message decode
   wire        par_ok = ^msg_r; // R16
   wire [1:0]  mode   = msg_r[sqd_pkg::B_MODE_HI:sqd_pkg::B_MODE_LO];
   wire        take   = frame_seen_r && cs_rise;
   wire        good   = take && par_ok;
   wire        wr     = msg_r[sqd_pkg::B_WRITE];

   // =====================================================
   // configuration and soft reset
   logic [1:0] per_r;
   logic       cond_r;
   logic       aa_seen_r;
   logic       soft_rst_r;
   wire        sys_rst = !rstn_in || soft_rst_r; // R22
   wire        rst_word = good && mode == sqd_pkg::MODE_REG && wr
                          && msg_r[sqd_pkg::B_RSEL];

   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         per_r  <= sqd_pkg::PER_RST; // R20
         cond_r <= sqd_pkg::COND_RST; // R19
      end else if (good && mode == sqd_pkg::MODE_REG && wr && !deploy_busy_in) begin
         cond_r <= msg_r[sqd_pkg::B_COND]; // R19
         if (!msg_r[sqd_pkg::B_RSEL]) begin
            per_r <= msg_r[sqd_pkg::B_PER_HI:sqd_pkg::B_PER_LO]; // R18
         end
      end
   end

   // any other completed transfer breaks the pair
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         aa_seen_r  <= 1'b0;
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= 1'b0;
         if (take) begin
            aa_seen_r <= rst_word && msg_r[7:0] == sqd_pkg::RST_PAT1; // R21
            if (rst_word && aa_seen_r && msg_r[7:0] == sqd_pkg::RST_PAT2
                && !deploy_busy_in) begin
               soft_rst_r <= 1'b1; // R22
            end
         end
      end
   end

   // =====================================================
   // diagnostic configuration
   logic       cur_en_r;
   logic       src_sel_r;
   logic       aout_r;
   logic [2:0] mon_ch_r;
   logic [2:0] cur_ch_r;
   logic       req_mos_r;
   logic       req_hs_r;
   logic       diag_ign_r;
   sqd_pkg::sqd_mos_e mos_st_r;
   wire diag_wr = good && mode == sqd_pkg::MODE_DIAG && wr && !deploy_busy_in;
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         cur_en_r  <= 1'b0;
         src_sel_r <= 1'b0;
         aout_r    <= 1'b0;
         mon_ch_r  <= 3'h0;
         cur_ch_r  <= 3'h0;
         req_mos_r <= 1'b0;
         req_hs_r  <= 1'b0;
      end else begin
         req_mos_r <= 1'b0;
         if (diag_wr) begin
            cur_en_r  <= msg_r[sqd_pkg::B_CUREN];
            src_sel_r <= msg_r[sqd_pkg::B_SRCSEL];
            aout_r    <= msg_r[sqd_pkg::B_AOUTEN];
            mon_ch_r  <= msg_r[sqd_pkg::B_MON_HI:sqd_pkg::B_MON_LO];
            cur_ch_r  <= msg_r[sqd_pkg::B_CUR_HI:sqd_pkg::B_CUR_LO];
            req_mos_r <= msg_r[sqd_pkg::B_MOSEN]; // R24
            req_hs_r  <= msg_r[sqd_pkg::B_HSSEL]; // R24
         end
      end
   end
   // measure pair only without mos diagnostic
   wire meas_on = cur_en_r && src_sel_r && mos_st_r == sqd_pkg::MOS_IDLE;
   assign measure_current_source_out = meas_on; // R02
   assign measure_current_sink_out   = meas_on; // R02
   assign bias_current_source_out    = cur_en_r && !src_sel_r;
   assign aout_enable_out            = aout_r; // R02
   assign monitor_chan_out           = mon_ch_r;
   assign current_chan_out           = cur_ch_r;

   // =====================================================
   // mos diagnostic sequencer
   logic [31:0]       tmo_r;
   logic [2:0]        stat_r;
   wire pre_ok = !cmpf.gnd_short && !cmpf.batt_short; // R05 R09
   // a refused request is flagged in its own response, not one frame later
   wire diag_flag = (wr && msg_r[sqd_pkg::B_MOSEN]) ? !pre_ok : diag_ign_r; // R05 R09
   wire stop   = cmpf.gnd_short || cmpf.batt_short || cmpf.over_current; // R06 R10
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         mos_st_r   <= sqd_pkg::MOS_IDLE;
         tmo_r      <= 32'h0;
         diag_ign_r <= 1'b0;
         stat_r     <= 3'h0;
      end else begin
         unique case (mos_st_r)
            sqd_pkg::MOS_IDLE: begin
               tmo_r <= 32'h0;
               if (req_mos_r) begin
                  diag_ign_r <= !pre_ok; // R05 R09
                  stat_r     <= 3'h0;
                  if (pre_ok) begin
                     mos_st_r <= req_hs_r ? sqd_pkg::MOS_HS : sqd_pkg::MOS_LS;
                  end
               end
            end
            sqd_pkg::MOS_LS, sqd_pkg::MOS_HS: begin
               tmo_r  <= tmo_r + 32'h1;
               stat_r <= stat_r | cmpf; // R07
               if (stop || tmo_r >= 32'(TIMEOUT_CYCLES - 1)) begin // R08 R11
                  mos_st_r <= sqd_pkg::MOS_IDLE; // R06 R10
               end
            end
            default: mos_st_r <= sqd_pkg::MOS_IDLE;
         endcase
      end
   end

   // driver gating: deploy enable and lost ground veto the switch
   always_comb begin
      drv_out = '0;
      if (den_s2_r && !ground_lost_in[mon_ch_r]) begin // R04 R23 R12
         drv_out.ls_on[mon_ch_r] = mos_st_r == sqd_pkg::MOS_LS;
         drv_out.hs_on[mon_ch_r] = mos_st_r == sqd_pkg::MOS_HS;
      end
   end

   // =====================================================
   // command outputs
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         deploy_cmd_out     <= 8'h00;
         deploy_cmd_stb_out <= 1'b0;
      end else begin
         deploy_cmd_stb_out <= good && mode == sqd_pkg::MODE_CMD;
         if (good && mode == sqd_pkg::MODE_CMD) begin
            deploy_cmd_out <= msg_r[7:0];
         end
      end
   end
   assign stretch_period_out = per_r;
   assign deploy_cond_out    = cond_r;
   assign soft_reset_out     = soft_rst_r;

   // =====================================================
   // response word, kept across soft reset
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rsp_r <= {sqd_pkg::RSP_FAULT, 13'h0000};
      end else if (take) begin // R13
         if (!par_ok) begin
            rsp_r <= {sqd_pkg::RSP_FAULT, 13'h0000}; // R15
         end else begin
            unique case (mode)
               sqd_pkg::MODE_REG: begin
                  if (deploy_busy_in) begin
                     rsp_r <= {sqd_pkg::RSP_FAULT, 13'h0000};
                  end else begin
                     rsp_r <= {sqd_pkg::RSP_REG, 2'b00, cond_r, per_r, 8'h00}; // R17
                  end
               end
               sqd_pkg::MODE_CMD: rsp_r <= {sqd_pkg::RSP_CMD, 5'h00, msg_r[7:0]};
               sqd_pkg::MODE_DIAG: begin
                  if (deploy_busy_in) begin
                     rsp_r <= {sqd_pkg::RSP_FAULT, 13'h0000};
                  end else begin
                     // d13/d7 flag an ignored mos request
                     rsp_r <= {diag_flag ? sqd_pkg::RSP_DIAGF : sqd_pkg::RSP_DIAG,
                               2'b00, stat_r[0], stat_r[2], 1'b0, diag_flag,
                               cmpf.batt_short, cmpf.gnd_short, 5'h00}; // R01 R05
                  end
               end
               sqd_pkg::MODE_MON: rsp_r <= {sqd_pkg::RSP_STAT, 5'h00, ground_lost_in};
            endcase
         end
      end
   end
endmodule : sqd_ctrl

// ===== test/sqd_ctrl_monitor.sv
// checker: port-level assertions for the squib driver control block
`timescale 1ns/100ps
module sqd_ctrl_monitor #(
   parameter int TIMEOUT_CYCLES = 50,
   parameter int FILTER_CYCLES  = 3
) (
   // system
   input wire logic              clk_in,
   input wire logic              rstn_in,
   // spi and analog side
   input wire logic              csn_in,
   input wire logic              miso_oen_out,
   input wire sqd_pkg::sqd_cmp_s cmp_in,
   input wire logic              deploy_enable_input_in,
   input wire logic              deploy_busy_in,
   // observed results
   input wire sqd_pkg::sqd_drv_s drv_out,
   input wire logic [1:0]        stretch_period_out,
   input wire logic              deploy_cond_out,
   input wire logic              deploy_cmd_stb_out,
   input wire logic              soft_reset_out
);
   // =====================================================
   // run-length counters
   int on_cnt_r;
   int cmp_cnt_r;
   always_ff @(posedge clk_in) begin
      on_cnt_r <= (!rstn_in || drv_out == '0) ? 0 : on_cnt_r + 1;
   end
   always_ff @(posedge clk_in) begin
      cmp_cnt_r <= (!rstn_in || cmp_in == '0) ? 0 : cmp_cnt_r + 1;
   end
   // =====================================================
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // enable low long enough to pass its two-stage synchroniser
   sequence s_en_low;
      !deploy_enable_input_in [*5];
   endsequence
   sequence s_cleared;
      stretch_period_out == sqd_pkg::PER_RST && deploy_cond_out == sqd_pkg::COND_RST;
   endsequence
   property p_oen;
      miso_oen_out == csn_in;
   endproperty
   property p_en_low;
      s_en_low |-> drv_out == '0;
   endproperty
   property p_one_driver;
      $onehot0(drv_out);
   endproperty
   property p_timeout;
      on_cnt_r <= TIMEOUT_CYCLES + 8;
   endproperty
   property p_cut;
      cmp_cnt_r > FILTER_CYCLES + 6 |-> drv_out == '0;
   endproperty
   property p_stb;
      deploy_cmd_stb_out |=> !deploy_cmd_stb_out;
   endproperty
   property p_srst;
      soft_reset_out |-> ##[0:2] s_cleared;
   endproperty
   property p_srst_busy;
      deploy_busy_in && $past(deploy_busy_in) |-> !soft_reset_out;
   endproperty
   property p_cfg;
      !$stable(stretch_period_out) || !$stable(deploy_cond_out) |-> csn_in;
   endproperty
   a_oen: assert property (p_oen) else $error("miso enable differs from select");
   a_en_low: assert property (p_en_low) else $error("driver on with enable low");
   a_one_driver: assert property (p_one_driver) else $error("two drivers on");
   a_timeout: assert property (p_timeout) else $error("driver on past timeout");
   a_cut: assert property (p_cut) else $error("driver on after comparator");
   a_stb: assert property (p_stb) else $error("command strobe too long");
   a_srst: assert property (p_srst) else $error("soft reset left config");
   a_srst_busy: assert property (p_srst_busy) else $error("soft reset while busy");
   a_cfg: assert property (p_cfg) else $error("config changed in frame");
endmodule : sqd_ctrl_monitor

bind sqd_ctrl sqd_ctrl_monitor #(
   .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
   .FILTER_CYCLES  (FILTER_CYCLES)
) u_sqd_ctrl_monitor (
   .clk_in (clk_in), .rstn_in (rstn_in), .csn_in (csn_in), .miso_oen_out (miso_oen_out),
   .cmp_in (cmp_in), .deploy_enable_input_in (deploy_enable_input_in),
   .deploy_busy_in (deploy_busy_in), .drv_out (drv_out),
   .stretch_period_out (stretch_period_out), .deploy_cond_out (deploy_cond_out),
   .deploy_cmd_stb_out (deploy_cmd_stb_out), .soft_reset_out (soft_reset_out)
);

// ===== test/sqd_host.sv
// host model: spi master sending framed 16-bit words
`timescale 1ns/100ps
module sqd_host (
   // spi master side
   output logic      sclk_out,
   output logic      csn_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      mosi_out = 1'b0;
      // select settles after time zero so the async clears see an edge
      #1 csn_out = 1'b1;
   end
   // clock runs only inside a frame, 32 ns period; bad flips the parity
   task automatic xfer(input logic [15:0] w, input logic bad, output logic [15:0] r);
      logic [15:0] m;
      m = w;
      m[sqd_pkg::B_PARITY] = 1'b0;
      m[sqd_pkg::B_PARITY] = ~(^m) ^ bad;
      csn_out = 1'b0;
      mosi_out = m[15];
      for (int i = 15; i >= 0; i--) begin
         #16 sclk_out = 1'b1;
         r[i] = miso_in;
         #16 sclk_out = 1'b0;
         // released line shows the inverse so a stale bit cannot pass
         mosi_out = (i > 0) ? m[i-1] : ~m[0];
      end
      #16 csn_out = 1'b1;
      #120;
   endtask : xfer
endmodule : sqd_host

// ===== test/test_squib_driver_spi_diag_control.sv
// testbench: spi word sequences against the squib driver control block
`timescale 1ns/100ps
module test_squib_driver_spi_diag_control;
   localparam int          TO = 50;
   localparam int          FL = 3;
   localparam logic [15:0] LS = 16'h9800;
   localparam logic [15:0] HS = 16'h9c00;
   localparam logic [7:0]  CMDS [3] = '{8'h01, 8'h80, 8'h5a};
   logic                   clk_in, rstn_in, sclk_in, csn_in, mosi_in, miso_out;
   logic                   den, busy, bias, src, sink, aout_en, cond, stb, srst;
   logic [7:0]             ground_lost_in, deploy_cmd_out;
   logic [2:0]             mon_ch, cur_ch;
   logic [1:0]             stretch_period_out;
   logic [15:0]            rsp;
   sqd_pkg::sqd_cmp_s      cmp_in;
   sqd_pkg::sqd_drv_s      drv_out;
   int                     n_errors, cmp_count, n_srst, n_stb;

   sqd_ctrl #(.TIMEOUT_CYCLES (TO), .FILTER_CYCLES (FL)) u_sqd_ctrl (
      .clk_in (clk_in), .rstn_in (rstn_in), .sclk_in (sclk_in), .csn_in (csn_in),
      .mosi_in (mosi_in), .miso_out (miso_out), .miso_oen_out (), .cmp_in (cmp_in),
      .deploy_enable_input_in (den), .ground_lost_in (ground_lost_in),
      .deploy_busy_in (busy), .drv_out (drv_out), .bias_current_source_out (bias),
      .measure_current_source_out (src), .measure_current_sink_out (sink),
      .aout_enable_out (aout_en), .monitor_chan_out (mon_ch), .current_chan_out (cur_ch),
      .stretch_period_out (stretch_period_out), .deploy_cond_out (cond),
      .deploy_cmd_out (deploy_cmd_out), .deploy_cmd_stb_out (stb), .soft_reset_out (srst));
   sqd_host u_sqd_host (.sclk_out (sclk_in), .csn_out (csn_in), .mosi_out (mosi_in),
      .miso_in (miso_out));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (srst === 1'b1) n_srst++;
      if (stb === 1'b1) n_stb++;
   end
   // =====================================================
   // tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic xf(input logic [15:0] w, input logic bad = 1'b0);
      u_sqd_host.xfer(w, bad, rsp);
      @(negedge clk_in);
   endtask : xf
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   initial begin
      repeat (30000) @(posedge clk_in);
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      summarize();
   end
   // =====================================================
   // tests
   initial begin
      rstn_in = 1'b1;
      #1 rstn_in = 1'b0;
      cmp_in = '0;
      den = 1'b1;
      busy = 1'b0;
      ground_lost_in = '0;
      repeat (3) @(negedge clk_in);
      rstn_in = 1'b1;
      xf(16'h0000);
      chk(rsp, 16'he000, "reset word");
      xf(16'h0000);
      chk(rsp, 16'h0000, "register defaults");
      $display("test reset done");
      for (int p = 0; p < 4; p++) begin
         xf(16'h10aa | 16'(p) << 8 | (p == 3 ? 16'h0400 : 16'h0000));
         chk(stretch_period_out, 16'(p), "period");
         chk(cond, p == 3, "condition");
         xf(16'h0000);
         // a write is answered with the settings it found
         chk(rsp, 16'(p == 0 ? 0 : p - 1) << 8, "reg response");
      end
      chk(n_srst, 0, "period write reset");
      xf(16'h0000, 1'b1);
      chk(rsp, 16'h0700, "read back");
      xf(16'h0000);
      chk(rsp, 16'he000, "bad parity");
      $display("test register done");
      xf(16'h18aa);
      xf(16'h0000);
      xf(16'h1855);
      chk(n_srst, 0, "broken pair");
      busy = 1'b1;
      xf(16'h18aa);
      xf(16'h1855);
      busy = 1'b0;
      chk(rsp, 16'he000, "reg while deploying");
      chk(n_srst, 0, "pair while deploying");
      chk(stretch_period_out, 16'h3, "period kept");
      xf(16'h18aa);
      xf(16'h1855);
      chk(n_srst, 1, "soft reset");
      chk(stretch_period_out, 16'h0, "period cleared");
      $display("test soft reset done");
      foreach (CMDS[i]) begin
         xf(16'h4000 | 16'(CMDS[i]));
         chk(deploy_cmd_out, 16'(CMDS[i]), "deploy command");
         xf(16'hc000);
         chk(rsp, 16'h4000 | 16'(CMDS[i]), "command echo");
      end
      chk(n_stb, 3, "command strobes");
      ground_lost_in = 8'ha4;
      xf(16'hc000);
      xf(16'hc000);
      chk(rsp, 16'hc0a4, "status");
      $display("test command done");
      for (int s = 0; s < 2; s++) begin
         cmp_in = s ? 3'b100 : 3'b010;
         xf(s ? HS : LS);
         chk(drv_out, 16'h0000, "failed precheck");
         cmp_in = '0;
         xf(16'h8000);
         chk({rsp[15:13], rsp[7]}, 4'hb, "precheck flags");
      end
      den = 1'b0;
      xf(LS);
      repeat (TO) @(negedge clk_in);
      chk(drv_out, 16'h0000, "enable low");
      den = 1'b1;
      repeat (TO) @(negedge clk_in);
      for (int s = 0; s < 2; s++) begin
         xf(s ? HS : LS);
         chk(drv_out, s ? 16'h0100 : 16'h0001, "driver on");
         cmp_in = 3'b001;
         @(negedge clk_in);
         cmp_in = '0;
         repeat (10) @(negedge clk_in);
         chk(drv_out, s ? 16'h0100 : 16'h0001, "glitch ignored");
         cmp_in = s ? 3'b100 : 3'b001;
         repeat (FL + 8) @(negedge clk_in);
         chk(drv_out, 16'h0000, "terminated");
         cmp_in = '0;
         // the request's own response predates the run; read twice
         xf(16'h8000);
         xf(16'h8000);
         chk({rsp[15:13], rsp[10:9]}, s ? 5'b10001 : 5'b10010, "status bits");
      end
      for (int s = 0; s < 2; s++) begin
         xf(s ? HS : LS);
         chk(drv_out, s ? 16'h0100 : 16'h0001, "driver on");
         repeat (TO + 10) @(negedge clk_in);
         chk(drv_out, 16'h0000, "timeout");
      end
      $display("test mos diagnostic done");
      xf(16'h93a5);
      chk({src, sink, aout_en}, 3'h7, "measure on");
      chk({mon_ch, cur_ch}, 6'h15, "channel select");
      xf(16'h9200);
      chk({bias, src, sink}, 3'h4, "bias only");
      $display("test measurement done");
      summarize();
   end
endmodule : test_squib_driver_spi_diag_control
